// ===== rsbw_remote_write.sv
// remote access state machine for slow buffered writes, with wishbone registers
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module rsbw_remote_write (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // remote processor side
    input wire rsbw_pkg::rsbw_remote_type remote_i,
    output logic transfer_ack_o,
    // local timing control unit side
    input wire rsbw_pkg::rsbw_local_type local_i,
    output logic local_bus_grant_o,
    output logic local_cpu_wait_o,
    // memory side
    output logic local_bus_select_o,
    output logic bus_float_o,
    output logic data_write_n_o,
    output logic instr_write_n_o,
    output logic [15:0] instr_word_o,
    output logic [15:0] program_counter_o
);
    import rsbw_pkg::*;

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    rsbw_state_type state_reg;
    rsbw_state_type state_next;
    logic lock_out_remote_reg;
    logic [4:0] device_control_reg;
    logic [7:0] remote_interface_config;
    logic [7:0] ric_pending_reg;
    logic ric_pending_valid_reg;
    logic high_byte_flag;
    logic [7:0] instr_holding_latch;
    logic [2:0] wait_cnt_reg;
    logic [1:0] access_kind_reg;
    logic remote_start;
    logic wait_done;
    logic wb_req;
    logic wb_wr;
    logic [1:0] memory_select;

    // true when the buses are handed to the remote side
    function automatic logic rsbw_remote_owns(input rsbw_state_type s);
        rsbw_remote_owns = (s != RSBW_ST_IDLE1) && (s != RSBW_ST_IDLE2)
            && (s != RSBW_ST_IDLE3);
    endfunction : rsbw_remote_owns

    // true in any of the access states
    function automatic logic rsbw_is_access(input rsbw_state_type s);
        rsbw_is_access = (s == RSBW_ST_D_RIC) || (s == RSBW_ST_D_PCL)
            || (s == RSBW_ST_D_PCH) || (s == RSBW_ST_D_DATA_MEMORY)
            || (s == RSBW_ST_D_ILOW) || (s == RSBW_ST_D_IHIGH);
    endfunction : rsbw_is_access

    assign remote_start = remote_i.enable & remote_i.write;
    assign memory_select = remote_interface_config[RSBW_RIC_MS_LSB +: 2];
    // remote wait extends past the last programmed wait
    assign wait_done = (wait_cnt_reg == 3'h0) & remote_i.wait_n;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land on the edge where the master samples ack high, never earlier
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // one state per clock
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RSBW_ST_IDLE1, RSBW_ST_IDLE2, RSBW_ST_IDLE3: begin
                if (!remote_start) begin
                    state_next = RSBW_ST_IDLE1;
                end else if (lock_out_remote_reg || local_bus_grant_o) begin
                    // held off by lockout or local grant
                    state_next = RSBW_ST_IDLE2;
                end else if (!local_i.request) begin
                    state_next = RSBW_ST_TAKEOVER;
                end
            end
            RSBW_ST_TAKEOVER: begin
                // wait until the local write strobe is gone
                if (!local_i.write_active) begin
                    state_next = RSBW_ST_LOAD;
                end
            end
            RSBW_ST_LOAD: begin
                // command select goes to the config register
                if (remote_i.cmd) begin
                    state_next = RSBW_ST_D_RIC;
                end else begin
                    case (memory_select)
                        RSBW_MS_PCL: state_next = RSBW_ST_D_PCL;
                        RSBW_MS_PCH: state_next = RSBW_ST_D_PCH;
                        RSBW_MS_DATA_MEMORY: state_next = RSBW_ST_D_DATA_MEMORY;
                        default: begin
                            state_next = high_byte_flag ? RSBW_ST_D_IHIGH
                                : RSBW_ST_D_ILOW;
                        end
                    endcase
                end
            end
            RSBW_ST_D_RIC, RSBW_ST_D_PCL, RSBW_ST_D_PCH, RSBW_ST_D_DATA_MEMORY,
            RSBW_ST_D_ILOW, RSBW_ST_D_IHIGH: begin
                if (wait_done) begin
                    state_next = RSBW_ST_TERM;
                end
            end
            RSBW_ST_TERM: begin
                // loop until the remote write is removed
                if (!remote_start) begin
                    state_next = RSBW_ST_RELEASE;
                end
            end
            RSBW_ST_RELEASE: begin
                state_next = RSBW_ST_IDLE3;
            end
            default: begin
                state_next = RSBW_ST_IDLE1;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= RSBW_ST_IDLE1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // wait counters
    // ------------------------------------------------------------
    // load from the control register fields in the load state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_cnt_reg <= 3'h0;
        end else if (state_next == RSBW_ST_LOAD) begin
            if (!remote_i.cmd && memory_select == RSBW_MS_INSTRUCTION_MEMORY) begin
                wait_cnt_reg <= {1'b0, device_control_reg[RSBW_DCR_IW_LSB +: 2]};
            end else if (!remote_i.cmd && memory_select == RSBW_MS_DATA_MEMORY) begin
                wait_cnt_reg <= device_control_reg[RSBW_DCR_DW_LSB +: 3];
            end else begin
                wait_cnt_reg <= 3'h0;
            end
        end else if (rsbw_is_access(state_reg) && wait_cnt_reg != 3'h0) begin
            wait_cnt_reg <= wait_cnt_reg - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // handshake outputs, registered from the next state
    // ------------------------------------------------------------
    // registered outputs lag the pins by one clock; the ack still falls
    // before any bus takeover since takeover itself needs a clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transfer_ack_o <= 1'b1;
            local_bus_select_o <= 1'b0;
            local_bus_grant_o <= 1'b0;
            local_cpu_wait_o <= 1'b0;
        end else begin
            // ack low while waiting, high from termination
            transfer_ack_o <= !(remote_start && state_next != RSBW_ST_TERM);
            // select high from load through release
            local_bus_select_o <= rsbw_remote_owns(state_next)
                && state_next != RSBW_ST_TAKEOVER;
            // grant only in the idle states, the third idle only once the remote write is gone
            local_bus_grant_o <= local_i.request && local_i.lock
                && (state_next == RSBW_ST_IDLE1 || state_next == RSBW_ST_IDLE2
                || (state_next == RSBW_ST_IDLE3 && !remote_start));
            // stall the cpu while the remote side owns the bus
            local_cpu_wait_o <= local_i.request && rsbw_remote_owns(state_next);
        end
    end

    // float changes half a period after each state edge
    always_ff @(negedge clk_i) begin
        if (rst_i) begin
            bus_float_o <= 1'b0;
        end else begin
            bus_float_o <= rsbw_remote_owns(state_reg);
        end
    end

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_write_n_o <= 1'b1;
            instr_write_n_o <= 1'b1;
        end else begin
            // data strobe ends with the remote write
            data_write_n_o <= !((state_next == RSBW_ST_D_DATA_MEMORY
                || (state_next == RSBW_ST_TERM && access_kind_reg == RSBW_MS_DATA_MEMORY
                && !remote_i.cmd)) && remote_start);
            // high byte strobe from load onward
            instr_write_n_o <= !(remote_start && high_byte_flag && !remote_i.cmd
                && ((state_next == RSBW_ST_LOAD && memory_select == RSBW_MS_INSTRUCTION_MEMORY)
                || state_next == RSBW_ST_D_IHIGH
                || (state_next == RSBW_ST_TERM && access_kind_reg == RSBW_MS_INSTRUCTION_MEMORY)));
        end
    end

    // remembers which target the current access hit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            access_kind_reg <= RSBW_MS_DATA_MEMORY;
        end else if (state_next == RSBW_ST_LOAD) begin
            access_kind_reg <= remote_i.cmd ? RSBW_MS_PCL : memory_select;
        end
    end

    // ------------------------------------------------------------
    // instruction word assembly
    // ------------------------------------------------------------
    // low byte to latch, high byte joins it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_holding_latch <= 8'h00;
            instr_word_o <= 16'h0000;
        end else if (state_next == RSBW_ST_D_ILOW) begin
            instr_holding_latch <= remote_i.data;
        end else if (state_next == RSBW_ST_LOAD && high_byte_flag
            && !remote_i.cmd && memory_select == RSBW_MS_INSTRUCTION_MEMORY) begin
            instr_word_o <= {remote_i.data, instr_holding_latch};
        end
    end

    // flag cleared by reset or select 01, toggled at release of an instruction memory write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_byte_flag <= 1'b0;
        end else if ((wb_wr && wb_adr_i == RSBW_ADDR_RIC
            && wb_dat_i[RSBW_RIC_MS_LSB +: 2] == RSBW_MS_INSTRUCTION_MEMORY)
            || (state_reg == RSBW_ST_D_RIC && state_next == RSBW_ST_TERM
            && remote_i.data[RSBW_RIC_MS_LSB +: 2] == RSBW_MS_INSTRUCTION_MEMORY)) begin
            high_byte_flag <= 1'b0;
        end else if (state_reg == RSBW_ST_RELEASE && access_kind_reg == RSBW_MS_INSTRUCTION_MEMORY) begin
            high_byte_flag <= ~high_byte_flag;
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    // byte writes, increment after the high byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            program_counter_o <= RSBW_PC_RESET;
        end else if (state_reg == RSBW_ST_D_PCL && state_next == RSBW_ST_TERM) begin
            program_counter_o[7:0] <= remote_i.data;
        end else if (state_reg == RSBW_ST_D_PCH && state_next == RSBW_ST_TERM) begin
            program_counter_o[15:8] <= remote_i.data;
        end else if (wb_wr && wb_adr_i == RSBW_ADDR_PC) begin
            program_counter_o <= wb_dat_i[15:0];
        end else if (state_reg == RSBW_ST_RELEASE && access_kind_reg == RSBW_MS_INSTRUCTION_MEMORY
            && high_byte_flag) begin
            program_counter_o <= program_counter_o + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // remote interface config
    // ------------------------------------------------------------
    // remote value held until one period after the write ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ric_pending_reg <= RSBW_RIC_RESET;
            ric_pending_valid_reg <= 1'b0;
        end else if (state_reg == RSBW_ST_D_RIC && state_next == RSBW_ST_TERM) begin
            ric_pending_reg <= remote_i.data;
            ric_pending_valid_reg <= 1'b1;
        end else if (state_reg == RSBW_ST_RELEASE) begin
            ric_pending_valid_reg <= 1'b0;
        end
    end

    // config register: software writes, remote commit at release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remote_interface_config <= RSBW_RIC_RESET;
        end else if (state_reg == RSBW_ST_RELEASE && ric_pending_valid_reg) begin
            remote_interface_config <= ric_pending_reg;
        end else if (wb_wr && wb_adr_i == RSBW_ADDR_RIC) begin
            remote_interface_config <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // software control registers
    // ------------------------------------------------------------
    // lockout and wait fields, byte lane 0 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_out_remote_reg <= 1'b0;
            device_control_reg <= RSBW_DCR_RESET;
        end else if (wb_wr && wb_adr_i == RSBW_ADDR_CTRL) begin
            lock_out_remote_reg <= wb_dat_i[RSBW_CTRL_LOR_BIT];
        end else if (wb_wr && wb_adr_i == RSBW_ADDR_DCR) begin
            device_control_reg <= wb_dat_i[4:0];
        end
    end

    // ------------------------------------------------------------
    // wishbone answer
    // ------------------------------------------------------------
    // one-cycle ack a clock after the strobe; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RSBW_UNMAPPED_DATA;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_adr_i == RSBW_ADDR_CTRL) begin
                wb_dat_o <= {31'h0000_0000, lock_out_remote_reg};
            end else if (wb_adr_i == RSBW_ADDR_DCR) begin
                wb_dat_o <= {27'h000_0000, device_control_reg};
            end else if (wb_adr_i == RSBW_ADDR_RIC) begin
                wb_dat_o <= {24'h00_0000, remote_interface_config};
            end else if (wb_adr_i == RSBW_ADDR_STATUS) begin
                wb_dat_o <= {23'h00_0000, high_byte_flag, 4'h0, state_reg};
            end else if (wb_adr_i == RSBW_ADDR_IWORD) begin
                wb_dat_o <= {16'h0000, instr_word_o};
            end else if (wb_adr_i == RSBW_ADDR_PC) begin
                wb_dat_o <= {16'h0000, program_counter_o};
            end else begin
                wb_dat_o <= RSBW_UNMAPPED_DATA;
            end
        end
    end

endmodule : rsbw_remote_write

`default_nettype wire

// ===== rsbw_pkg.sv
// shared constants, types and register map of the remote slow buffered write port
package rsbw_pkg;

    // ------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] RSBW_ADDR_CTRL = 8'h00;
    localparam logic [7:0] RSBW_ADDR_DCR = 8'h04;
    localparam logic [7:0] RSBW_ADDR_RIC = 8'h08;
    localparam logic [7:0] RSBW_ADDR_STATUS = 8'h0C;
    localparam logic [7:0] RSBW_ADDR_IWORD = 8'h10;
    localparam logic [7:0] RSBW_ADDR_PC = 8'h14;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int RSBW_CTRL_LOR_BIT = 0;
    localparam int RSBW_DCR_DW_LSB = 0;
    localparam int RSBW_DCR_IW_LSB = 3;
    localparam int RSBW_RIC_MS_LSB = 0;
    localparam int RSBW_STAT_HIB_BIT = 8;
    localparam logic [4:0] RSBW_DCR_RESET = 5'h00;
    localparam logic [7:0] RSBW_RIC_RESET = 8'h00;
    localparam logic [15:0] RSBW_PC_RESET = 16'h0000;
    localparam logic [31:0] RSBW_UNMAPPED_DATA = 32'h0000_0000;

    // memory select encodings
    localparam logic [1:0] RSBW_MS_DATA_MEMORY = 2'b00;
    localparam logic [1:0] RSBW_MS_INSTRUCTION_MEMORY = 2'b01;
    localparam logic [1:0] RSBW_MS_PCL = 2'b10;
    localparam logic [1:0] RSBW_MS_PCH = 2'b11;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        RSBW_ST_IDLE1, RSBW_ST_IDLE2, RSBW_ST_TAKEOVER, RSBW_ST_LOAD,
        RSBW_ST_D_RIC, RSBW_ST_D_PCL, RSBW_ST_D_PCH, RSBW_ST_D_DATA_MEMORY,
        RSBW_ST_D_ILOW, RSBW_ST_D_IHIGH, RSBW_ST_TERM, RSBW_ST_RELEASE,
        RSBW_ST_IDLE3
    } rsbw_state_type;

    // remote processor request pins, all active high except wait_n
    typedef struct packed {
        logic enable;
        logic write;
        logic cmd;
        logic wait_n;
        logic [7:0] data;
    } rsbw_remote_type;

    // local timing control unit handshake
    typedef struct packed {
        logic request;
        logic lock;
        logic write_active;
    } rsbw_local_type;

endpackage : rsbw_pkg

// ===== rsbw_remote_write_properties.sv
// assertion checker for the remote slow buffered write port
`timescale 1ns/1ps
`default_nettype none

module rsbw_remote_write_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // remote and local sides
    input wire rsbw_pkg::rsbw_remote_type remote_i,
    input wire logic transfer_ack_o,
    input wire logic local_bus_grant_o,
    // memory side
    input wire logic local_bus_select_o,
    input wire logic bus_float_o,
    input wire logic data_write_n_o,
    input wire logic instr_write_n_o
);
    import rsbw_pkg::*;
    logic rw;
    // remote write condition as the state machine sees it
    assign rw = remote_i.enable && remote_i.write;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // select held through release, dropped in the third idle state
    sequence s_release;
        local_bus_select_o ##1 !local_bus_select_o;
    endsequence
    property p_ack_on_write;
        $rose(rw) && transfer_ack_o && !local_bus_select_o |=> !transfer_ack_o;
    endproperty
    property p_ack_cause;
        $fell(transfer_ack_o) |-> $past(rw);
    endproperty
    property p_hold_idle;
        local_bus_grant_o && rw |=> !local_bus_select_o;
    endproperty
    property p_no_grant;
        local_bus_select_o |-> !local_bus_grant_o;
    endproperty
    property p_float_first;
        $rose(local_bus_select_o) |-> bus_float_o && !transfer_ack_o;
    endproperty
    property p_data_owned;
        !data_write_n_o |-> local_bus_select_o && bus_float_o;
    endproperty
    property p_instr_owned;
        !instr_write_n_o |-> local_bus_select_o;
    endproperty
    property p_term_hold;
        transfer_ack_o && local_bus_select_o && rw |=> local_bus_select_o && transfer_ack_o;
    endproperty
    property p_release;
        $fell(rw) && transfer_ack_o && local_bus_select_o |=> s_release;
    endproperty
    property p_strobe_end;
        $fell(rw) && local_bus_select_o |=> data_write_n_o && instr_write_n_o;
    endproperty
    property p_float_end;
        $fell(local_bus_select_o) |-> !bus_float_o && $past(bus_float_o);
    endproperty
    a_ack_on_write: assert property (p_ack_on_write) else $error("ack high on write");
    a_ack_cause: assert property (p_ack_cause) else $error("ack fell unasked");
    a_hold_idle: assert property (p_hold_idle) else $error("took granted bus");
    a_no_grant: assert property (p_no_grant) else $error("grant during remote");
    a_float_first: assert property (p_float_first) else $error("bus not floated");
    a_data_owned: assert property (p_data_owned) else $error("data strobe unowned");
    a_instr_owned: assert property (p_instr_owned) else $error("instr strobe unowned");
    a_term_hold: assert property (p_term_hold) else $error("left termination");
    a_release: assert property (p_release) else $error("bad release order");
    a_strobe_end: assert property (p_strobe_end) else $error("strobe held");
    a_float_end: assert property (p_float_end) else $error("float not ended");
endmodule : rsbw_remote_write_checker

bind rsbw_remote_write rsbw_remote_write_checker u_checker (.clk_i(clk_i), .rst_i(rst_i),
    .remote_i(remote_i), .transfer_ack_o(transfer_ack_o), .local_bus_grant_o(local_bus_grant_o),
    .local_bus_select_o(local_bus_select_o), .bus_float_o(bus_float_o),
    .data_write_n_o(data_write_n_o), .instr_write_n_o(instr_write_n_o));
`default_nettype wire

// ===== rsbw_remote_host.sv
// behavioural remote host processor issuing slow buffered writes
`timescale 1ns/1ps
`default_nettype none

module rsbw_remote_host (
    // clock
    input wire logic clk_i,
    // device side
    input wire logic transfer_ack_i,
    output var rsbw_pkg::rsbw_remote_type remote_o
);
    import rsbw_pkg::*;
    int ack_low;
    // pins idle, wait line released
    initial begin
        remote_o = '{enable: 1'b0, write: 1'b0, cmd: 1'b0, wait_n: 1'b1, data: 8'h00};
        ack_low = 0;
    end
    // one write; ext keeps wait low for that many ack-low cycles
    task automatic send(input logic cmd, input logic [7:0] dat, input int ext);
        int n;
        n = 0;
        ack_low = 0;
        @(posedge clk_i);
        remote_o <= '{enable: 1'b1, write: 1'b1, cmd: cmd, wait_n: (ext == 0), data: dat};
        while (n < 300) begin
            @(posedge clk_i);
            n++;
            if (!transfer_ack_i) ack_low++;
            if (transfer_ack_i && ack_low > 0) break;
            if (ack_low >= ext) remote_o.wait_n <= 1'b1;
        end
        // a write that never finishes counts against the run
        if (n >= 300) testbench.fail_count++;
        // release after ack; byte lane no longer holds the data
        remote_o <= '{enable: 1'b0, write: 1'b0, cmd: !cmd, wait_n: 1'b1, data: ~dat};
        repeat (3) @(posedge clk_i);
    endtask : send
endmodule : rsbw_remote_host
`default_nettype wire

// ===== rsbw_testbench.sv
// self-checking testbench for the remote slow buffered write port
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rsbw_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    rsbw_local_type local_i = '0;
    rsbw_remote_type remote_i;
    logic wb_ack_o, transfer_ack_o, local_bus_grant_o, local_cpu_wait_o;
    logic local_bus_select_o, bus_float_o, data_write_n_o, instr_write_n_o;
    logic [31:0] wb_dat_o, q;
    logic [15:0] instr_word_o, program_counter_o;
    int fail_count = 0;
    int tests_run = 0;
    integer seed = 32'h1ad5_9802;
    int dw, n;
    int exp_pc = 0;
    logic [7:0] b, lo;
    logic [7:0] ibyte_q[$];

    // free-running clock, 50 ns period
    always #25 clk_i = ~clk_i;

    rsbw_remote_write dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .remote_i(remote_i),
        .transfer_ack_o(transfer_ack_o), .local_i(local_i),
        .local_bus_grant_o(local_bus_grant_o), .local_cpu_wait_o(local_cpu_wait_o),
        .local_bus_select_o(local_bus_select_o), .bus_float_o(bus_float_o),
        .data_write_n_o(data_write_n_o), .instr_write_n_o(instr_write_n_o),
        .instr_word_o(instr_word_o), .program_counter_o(program_counter_o));
    rsbw_remote_host host (.clk_i(clk_i), .transfer_ack_i(transfer_ack_o), .remote_o(remote_i));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // classic single wishbone cycle, read data left in q
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) fail_count++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb

    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // watchdog at 10000 cycles, far beyond the expected few hundred cycles
    initial begin
        #500_000;
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("idle", 32'h7, {transfer_ack_o, data_write_n_o, instr_write_n_o});
        chk("pc_reset", RSBW_PC_RESET, program_counter_o);
        wb(0, RSBW_ADDR_DCR, 0);
        chk("dcr_reset", RSBW_DCR_RESET, q);
        wb(1, 8'h1C, 32'hFFFF_FFFF);
        wb(0, 8'h1C, 0);
        chk("unmapped", RSBW_UNMAPPED_DATA, q);
        for (int ms = 2; ms < 4; ms++) begin
            b = $random(seed);
            wb(1, RSBW_ADDR_RIC, ms);
            host.send(0, b, 0);
            exp_pc = (ms == 2) ? {exp_pc[15:8], b} : {b, exp_pc[7:0]};
            chk("pc_byte", exp_pc, program_counter_o);
        end
        // data memory with random data waits, last one stretched by wait
        for (int i = 0; i < 4; i++) begin
            dw = $random(seed) & 7;
            b = $random(seed);
            wb(1, RSBW_ADDR_DCR, dw);
            wb(1, RSBW_ADDR_RIC, RSBW_MS_DATA_MEMORY);
            host.send(0, b, (i == 3) ? dw + 6 : 0);
            if (i < 3) chk("data_memory_wait", 3 + dw, host.ack_low);
            else chk("data_memory_extend", 1, host.ack_low > 3 + dw);
        end
        // instruction byte pairing, realigned by select rewrite
        wb(1, RSBW_ADDR_RIC, RSBW_MS_INSTRUCTION_MEMORY);
        lo = $random(seed);
        host.send(0, lo, 0);
        wb(0, RSBW_ADDR_STATUS, 0);
        chk("flag_set", 1, q[8]);
        wb(1, RSBW_ADDR_RIC, RSBW_MS_INSTRUCTION_MEMORY);
        wb(0, RSBW_ADDR_STATUS, 0);
        chk("flag_clear", 0, q[8]);
        host.send(0, lo, 0);
        ibyte_q.push_back(lo);
        b = $random(seed);
        host.send(0, b, 0);
        ibyte_q.push_back(b);
        chk("iword", {ibyte_q[1], ibyte_q[0]}, instr_word_o);
        exp_pc = (exp_pc + 1) & 16'hFFFF;
        chk("pc_incr", exp_pc, program_counter_o);
        // remote config write switches target to counter low byte
        host.send(1, 8'h02, 0);
        wb(0, RSBW_ADDR_RIC, 0);
        chk("ric", 32'h2, q);
        b = $random(seed);
        host.send(0, b, 0);
        exp_pc = {exp_pc[15:8], b};
        chk("pc_after_ric", exp_pc, program_counter_o);
        wb(1, RSBW_ADDR_CTRL, 1);
        fork
            host.send(0, b, 0);
            begin
                repeat (10) @(posedge clk_i);
                chk("lockout", 0, {transfer_ack_o, local_bus_select_o});
                wb(1, RSBW_ADDR_CTRL, 0);
            end
        join
        local_i.lock <= 1'b1;
        local_i.request <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("grant", 1, local_bus_grant_o);
        wb(1, RSBW_ADDR_DCR, 7);
        wb(1, RSBW_ADDR_RIC, RSBW_MS_DATA_MEMORY);
        fork
            host.send(0, b, 0);
            begin
                repeat (6) @(posedge clk_i);
                chk("granted_hold", 0, local_bus_select_o);
                local_i.request <= 1'b0;
                n = 0;
                while (local_bus_select_o !== 1'b1 && n < 20) begin
                    @(posedge clk_i);
                    n++;
                end
                local_i.request <= 1'b1;
                repeat (2) @(posedge clk_i);
                chk("cpu_stall", 2, {local_cpu_wait_o, local_bus_grant_o});
                local_i.request <= 1'b0;
            end
        join
        local_i.write_active <= 1'b1;
        fork
            host.send(0, b, 0);
            begin
                repeat (5) @(posedge clk_i);
                chk("local_write", 0, local_bus_select_o);
                local_i.write_active <= 1'b0;
            end
        join
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
